//--- hw/cdd_map.svh
`ifndef CDD_MAP_SVH
`define CDD_MAP_SVH

// register bus widths
`define CDD_AW 10
`define CDD_DW 8

// register offsets
`define CDD_A_CAL 10'h018
`define CDD_A_ZD 10'h01e
`define CDD_A_STAT 10'h01f
`define CDD_A_DIV_MN 10'h190
`define CDD_A_DIV_CTL 10'h191
`define CDD_A_DIV_DCC 10'h192
`define CDD_DIV_STRIDE 10'h003
`define CDD_A_PREDIV 10'h1e0
`define CDD_A_SRC 10'h1e1
`define CDD_A_UPD 10'h232

// field positions
`define CDD_F_CAL_REQ 0
`define CDD_F_CAL_PRE 1
`define CDD_F_ZD_MODE 1
`define CDD_F_ZD_DIV 3
`define CDD_F_ST_DONE 6
`define CDD_F_ST_BUSY 7
`define CDD_F_N 0
`define CDD_F_M 4
`define CDD_F_PHASE 0
`define CDD_F_START 5
`define CDD_F_BYP 7
`define CDD_F_DCC_DIS 0
`define CDD_F_PREDIV 0
`define CDD_F_SRC 0
`define CDD_F_DIRECT 2
`define CDD_F_UPD 0

// reset values
`define CDD_RST_SRC 2'b10
`define CDD_RST_PREDIV 3'h1
`define CDD_RST_CAL_PRE 2'h3

// counts
`define CDD_CAL_CYCLES 4400
`define CDD_PREDIV_TOP 3'h5
`define CDD_CAL_DIV_BASE 5'h02

`endif

//--- hw/cdd_pkg.sv
package cdd_pkg;

  typedef enum logic [1:0] {
    CDD_SRC_EXT_DIV = 2'b00,
    CDD_SRC_EXT = 2'b01,
    CDD_SRC_OSC_DIV = 2'b10,
    CDD_SRC_BAD = 2'b11
  } cdd_src_e;

  typedef enum logic [1:0] {
    CDD_ZD_OFF = 2'b00,
    CDD_ZD_INT = 2'b01,
    CDD_ZD_RSV = 2'b10,
    CDD_ZD_EXT = 2'b11
  } cdd_zd_e;

  typedef enum logic {
    CDD_CAL_IDLE = 1'b0,
    CDD_CAL_RUN = 1'b1
  } cdd_cal_e;

  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cdd_bus_s;

  typedef struct packed {
    logic [3:0] m;
    logic [3:0] n;
    logic [3:0] phase;
    logic start_hi;
    logic byp;
    logic dcc_dis;
  } cdd_ccfg_s;

  typedef struct packed {
    logic [5:0] cnt;
    logic [4:0] dly;
    logic lvl;
  } cdd_chan_s;

  typedef struct packed {
    cdd_ccfg_s [3:0] cfg;
    cdd_chan_s [3:0] ch;
    logic cal_req;
    logic [1:0] cal_pre;
    cdd_zd_e zd_mode;
    logic [1:0] zd_div;
    logic [2:0] prediv;
    cdd_src_e src;
    logic direct;
    logic [2:0] ext_sync;
    logic ext_lvl;
    logic [2:0] pre_cnt;
    logic direct_out;
    cdd_cal_e cal;
    logic cal_last;
    logic cal_done;
    logic [4:0] cal_pre_cnt;
    logic [12:0] cal_cnt;
    logic fb_clk;
    logic [7:0] rdata;
  } cdd_st_s;

endpackage

//--- hw/cdd_top.sv
// How it works
// - one calibration lasts 4400 calibration clocks
// - duration equals 4400 times R times prescale
// - calibration starts only on explicit request
// - calibration holds all dividers in sync
// - mode 01 feeds divider 0 back
// - mode 11 feeds external clock back
// - two bits pick external feedback divider
// - all four dividers restart together
// - each channel divides by 1 to 32
// - shared pre-divider divides by 1 to 6
// - output high N+1, low M+1 cycles
// - optional duty fix for M=N+1 or M=N
// - coarse delay up to 15 input cycles
// - each output may start high or low
// - oscillator direct path bypasses all dividers
// - source select 00/01/10 legal, 11 not
// - status bit reads 1 when calibration done
// - calibration clock is detector rate over prescale
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "cdd_map.svh"

module cdd_top
  import cdd_pkg::*;
#(
  parameter int CAL_CYCLES = `CDD_CAL_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire cdd_bus_s bus,
  output logic [7:0] rdata,
  // clock sources
  input wire logic osc_edge,
  input wire logic ext_clk_pin,
  input wire logic pd_tick,
  // distribution outputs
  output logic [3:0] ch_out,
  output logic direct_out,
  output logic fb_clk,
  output logic [1:0] zd_div_sel,
  output logic sync_hold,
  output logic cal_done
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // pre-divider code 0..5 means divide by 1..6; larger codes clamp to 6
  function automatic logic [2:0] prediv_last(input logic [2:0] code);
    logic [2:0] c;
    c = (code > `CDD_PREDIV_TOP) ? `CDD_PREDIV_TOP : code;
    return c;
  endfunction

  // calibration prescale 2, 4, 8 or 16
  function automatic logic [4:0] cal_div(input logic [1:0] code);
    logic [4:0] d;
    d = `CDD_CAL_DIV_BASE << code;
    return d;
  endfunction

  // half-period lengths in input edges; counting edges, not cycles,
  // lets the duty fix land on the half cycle an odd ratio needs
  function automatic logic [5:0] phase_len(input cdd_ccfg_s c,
                                           input logic hi);
    logic fix;
    logic [5:0] len;
    fix = !c.dcc_dis && ((c.m == c.n) ||
          ({1'b0, c.m} == {1'b0, c.n} + 5'h01));
    if (fix) begin
      len = {2'h0, c.m} + {2'h0, c.n} + 6'h02;
    end else if (hi) begin
      len = {1'b0, c.n, 1'b0} + 6'h02;
    end else begin
      len = {1'b0, c.m, 1'b0} + 6'h02;
    end
    return len;
  endfunction

  function automatic cdd_chan_s chan_step(input cdd_chan_s s,
                                          input cdd_ccfg_s c,
                                          input logic tick,
                                          input logic hold);
    cdd_chan_s r;
    r = s;
    if (hold) begin
      r.lvl = c.start_hi;
      r.cnt = 6'h00;
      r.dly = {c.phase, 1'b0};
    end else if (tick) begin
      if (c.byp) begin
        r.lvl = ~s.lvl;
      end else if (s.dly != 5'h00) begin
        r.dly = s.dly - 5'h01;
      end else if (s.cnt + 6'h01 == phase_len(c, s.lvl)) begin
        r.cnt = 6'h00;
        r.lvl = ~s.lvl;
      end else begin
        r.cnt = s.cnt + 6'h01;
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  cdd_st_s st_ff;
  cdd_st_s nxt_st;

  logic ext_edge;
  logic raw_edge;
  logic use_pre;
  logic src_tick;
  logic hold;
  logic cal_start;
  logic cal_clk;
  logic [9:0] ch_off;
  logic [7:0] rd_val;

  always_comb begin
    nxt_st = st_ff;
    ext_edge = 1'b0;
    raw_edge = 1'b0;
    use_pre = 1'b0;
    src_tick = 1'b0;
    cal_start = 1'b0;
    cal_clk = 1'b0;
    ch_off = 10'h000;
    rd_val = 8'h00;

    // external clock pin: three flops, change taken once two agree
    nxt_st.ext_sync = {st_ff.ext_sync[1:0], ext_clk_pin};
    if ((st_ff.ext_sync[1] == st_ff.ext_sync[2]) &&
        (st_ff.ext_sync[2] != st_ff.ext_lvl)) begin
      ext_edge = 1'b1;
      nxt_st.ext_lvl = st_ff.ext_sync[2];
    end

    // source select; code 11 gives the dividers no input at all
    unique case (st_ff.src)
      CDD_SRC_EXT_DIV: begin
        raw_edge = ext_edge;
        use_pre = 1'b1;
      end
      CDD_SRC_EXT: begin
        raw_edge = ext_edge;
      end
      CDD_SRC_OSC_DIV: begin
        raw_edge = osc_edge;
        use_pre = 1'b1;
      end
      CDD_SRC_BAD: begin
        raw_edge = 1'b0;
      end
    endcase

    // shared pre-divider, counted in edges so odd ratios stay balanced
    if (!use_pre) begin
      src_tick = raw_edge;
      nxt_st.pre_cnt = 3'h0;
    end else if (raw_edge) begin
      if (st_ff.pre_cnt >= prediv_last(st_ff.prediv)) begin
        nxt_st.pre_cnt = 3'h0;
        src_tick = 1'b1;
      end else begin
        nxt_st.pre_cnt = st_ff.pre_cnt + 3'h1;
      end
    end

    // oscillator straight to the drivers, no divider on the way
    if (st_ff.direct && st_ff.src == CDD_SRC_OSC_DIV && osc_edge) begin
      nxt_st.direct_out = ~st_ff.direct_out;
    end else if (!st_ff.direct) begin
      nxt_st.direct_out = 1'b0;
    end

    // one shared hold and one shared tick keep the channels aligned
    hold = (st_ff.cal == CDD_CAL_RUN);
    for (int i = 0; i < 4; i++) begin
      nxt_st.ch[i] = chan_step(st_ff.ch[i], st_ff.cfg[i], src_tick,
                               hold);
    end

    // loop feedback routing
    unique case (st_ff.zd_mode)
      CDD_ZD_INT: nxt_st.fb_clk = st_ff.ch[0].lvl;
      CDD_ZD_EXT: nxt_st.fb_clk = st_ff.ext_lvl;
      CDD_ZD_OFF: nxt_st.fb_clk = 1'b0;
      CDD_ZD_RSV: nxt_st.fb_clk = 1'b0;
    endcase

    // calibration sequencer; runs off the detector tick only
    unique case (st_ff.cal)
      CDD_CAL_IDLE: begin
        nxt_st.cal_pre_cnt = 5'h00;
        nxt_st.cal_cnt = 13'h0000;
      end
      CDD_CAL_RUN: begin
        if (pd_tick) begin
          if (st_ff.cal_pre_cnt + 5'h01 == cal_div(st_ff.cal_pre)) begin
            nxt_st.cal_pre_cnt = 5'h00;
            cal_clk = 1'b1;
          end else begin
            nxt_st.cal_pre_cnt = st_ff.cal_pre_cnt + 5'h01;
          end
        end
        if (cal_clk) begin
          if (st_ff.cal_cnt == 13'(CAL_CYCLES - 1)) begin
            nxt_st.cal = CDD_CAL_IDLE;
            nxt_st.cal_done = 1'b1;
          end else begin
            nxt_st.cal_cnt = st_ff.cal_cnt + 13'h0001;
          end
        end
      end
    endcase

    // register writes
    if (bus.wr) begin
      unique case (bus.addr)
        `CDD_A_CAL: begin
          nxt_st.cal_req = bus.wdata[`CDD_F_CAL_REQ];
          nxt_st.cal_pre = bus.wdata[`CDD_F_CAL_PRE +: 2];
        end
        `CDD_A_ZD: begin
          nxt_st.zd_mode = cdd_zd_e'(bus.wdata[`CDD_F_ZD_MODE +: 2]);
          nxt_st.zd_div = bus.wdata[`CDD_F_ZD_DIV +: 2];
        end
        `CDD_A_PREDIV: nxt_st.prediv = bus.wdata[`CDD_F_PREDIV +: 3];
        `CDD_A_SRC: begin
          nxt_st.src = cdd_src_e'(bus.wdata[`CDD_F_SRC +: 2]);
          nxt_st.direct = bus.wdata[`CDD_F_DIRECT];
        end
        `CDD_A_UPD: begin
          // only a fresh request at update starts a run; rewriting
          // loop settings never does
          if (bus.wdata[`CDD_F_UPD]) begin
            nxt_st.cal_last = st_ff.cal_req;
            cal_start = st_ff.cal_req && !st_ff.cal_last;
          end
        end
        default: begin
          for (int i = 0; i < 4; i++) begin
            ch_off = 10'(i) * `CDD_DIV_STRIDE;
            if (bus.addr == `CDD_A_DIV_MN + ch_off) begin
              nxt_st.cfg[i].n = bus.wdata[`CDD_F_N +: 4];
              nxt_st.cfg[i].m = bus.wdata[`CDD_F_M +: 4];
            end
            if (bus.addr == `CDD_A_DIV_CTL + ch_off) begin
              nxt_st.cfg[i].phase = bus.wdata[`CDD_F_PHASE +: 4];
              nxt_st.cfg[i].start_hi = bus.wdata[`CDD_F_START];
              nxt_st.cfg[i].byp = bus.wdata[`CDD_F_BYP];
            end
            if (bus.addr == `CDD_A_DIV_DCC + ch_off) begin
              nxt_st.cfg[i].dcc_dis = bus.wdata[`CDD_F_DCC_DIS];
            end
          end
        end
      endcase
    end

    if (cal_start) begin
      nxt_st.cal = CDD_CAL_RUN;
      nxt_st.cal_done = 1'b0;
      nxt_st.cal_pre_cnt = 5'h00;
      nxt_st.cal_cnt = 13'h0000;
    end

    // register reads, answered in the next cycle; unmapped reads zero
    if (bus.rd) begin
      unique case (bus.addr)
        `CDD_A_CAL: begin
          rd_val[`CDD_F_CAL_REQ] = st_ff.cal_req;
          rd_val[`CDD_F_CAL_PRE +: 2] = st_ff.cal_pre;
        end
        `CDD_A_ZD: begin
          rd_val[`CDD_F_ZD_MODE +: 2] = st_ff.zd_mode;
          rd_val[`CDD_F_ZD_DIV +: 2] = st_ff.zd_div;
        end
        `CDD_A_STAT: begin
          rd_val[`CDD_F_ST_DONE] = st_ff.cal_done;
          rd_val[`CDD_F_ST_BUSY] = (st_ff.cal == CDD_CAL_RUN);
        end
        `CDD_A_PREDIV: rd_val[`CDD_F_PREDIV +: 3] = st_ff.prediv;
        `CDD_A_SRC: begin
          rd_val[`CDD_F_SRC +: 2] = st_ff.src;
          rd_val[`CDD_F_DIRECT] = st_ff.direct;
        end
        default: begin
          for (int i = 0; i < 4; i++) begin
            ch_off = 10'(i) * `CDD_DIV_STRIDE;
            if (bus.addr == `CDD_A_DIV_MN + ch_off) begin
              rd_val[`CDD_F_N +: 4] = st_ff.cfg[i].n;
              rd_val[`CDD_F_M +: 4] = st_ff.cfg[i].m;
            end
            if (bus.addr == `CDD_A_DIV_CTL + ch_off) begin
              rd_val[`CDD_F_PHASE +: 4] = st_ff.cfg[i].phase;
              rd_val[`CDD_F_START] = st_ff.cfg[i].start_hi;
              rd_val[`CDD_F_BYP] = st_ff.cfg[i].byp;
            end
            if (bus.addr == `CDD_A_DIV_DCC + ch_off) begin
              rd_val[`CDD_F_DCC_DIS] = st_ff.cfg[i].dcc_dis;
            end
          end
        end
      endcase
    end
    nxt_st.rdata = rd_val;
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.src <= cdd_src_e'(`CDD_RST_SRC);
      st_ff.prediv <= `CDD_RST_PREDIV;
      st_ff.cal_pre <= `CDD_RST_CAL_PRE;
      st_ff.zd_mode <= CDD_ZD_OFF;
      st_ff.cal <= CDD_CAL_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state flops

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ch_out[i] = st_ff.ch[i].lvl;
    end
  end

  assign rdata = st_ff.rdata;
  assign direct_out = st_ff.direct_out;
  assign fb_clk = st_ff.fb_clk;
  assign zd_div_sel = st_ff.zd_div;
  assign sync_hold = (st_ff.cal == CDD_CAL_RUN);
  assign cal_done = st_ff.cal_done;

endmodule

//--- dv/cdd_top_properties.sv
`timescale 1ns/1ps
module cdd_top_chk
  import cdd_pkg::*;
#(
  parameter int CAL_CYCLES = 4400
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire cdd_bus_s bus,
  input wire logic [7:0] rdata,
  // source and outputs
  input wire logic pd_tick,
  input wire logic [3:0] ch_out,
  input wire logic [1:0] zd_div_sel,
  input wire logic sync_hold,
  input wire logic cal_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [15:0] tick_ff;
  logic [15:0] nxt_tick;
  //////////////////////////////////////////////////////////////////////////
  // ticks of the current run; a restart in mid-run is not tracked
  always_comb begin
    nxt_tick = tick_ff;
    if (!sync_hold) begin
      nxt_tick = 16'h0000;
    end else if (pd_tick) begin
      nxt_tick = tick_ff + 16'h0001;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_ff <= 16'h0000;
    end else begin
      tick_ff <= nxt_tick;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  property p_rd_idle;
    !bus.rd |=> rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("rdata not zero after idle cycle");
  property p_stat;
    bus.rd && bus.addr == 10'h01f |=> rdata[6] == $past(cal_done);
  endproperty
  a_stat: assert property (p_stat)
    else $error("status bit differs from done");
  property p_done_low;
    sync_hold |-> !cal_done;
  endproperty
  a_done_low: assert property (p_done_low)
    else $error("done high during run");
  property p_start;
    $rose(sync_hold) |-> $past(bus.wr && bus.addr == 10'h232 && bus.wdata[0]);
  endproperty
  a_start: assert property (p_start)
    else $error("run began without update");
  property p_end;
    $fell(sync_hold) |-> cal_done && $past(pd_tick);
  endproperty
  a_end: assert property (p_end)
    else $error("hold released badly");
  property p_count;
    $fell(sync_hold) |-> tick_ff % CAL_CYCLES == 0 && tick_ff >= 2 * CAL_CYCLES;
  endproperty
  a_count: assert property (p_count)
    else $error("run length not a whole count");
  property p_frozen;
    $past(sync_hold, 2) && sync_hold |-> $stable(ch_out);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("outputs moved during hold");
  property p_zd_sel;
    $changed(zd_div_sel) |-> $past(bus.wr && bus.addr == 10'h01e);
  endproperty
  a_zd_sel: assert property (p_zd_sel)
    else $error("feedback select moved unasked");
endmodule

bind cdd_top cdd_top_chk #(.CAL_CYCLES(CAL_CYCLES)) u_chk (
  .clk(clk),
  .rst(rst),
  .bus(bus),
  .rdata(rdata),
  .pd_tick(pd_tick),
  .ch_out(ch_out),
  .zd_div_sel(zd_div_sel),
  .sync_hold(sync_hold),
  .cal_done(cal_done)
);

//--- dv/cdd_src_model.sv
`timescale 1ns/1ps
module cdd_src_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // board loop-back
  input wire logic loop_sel,
  input wire logic loop_in,
  // sources
  output logic osc_edge,
  output logic pd_tick,
  output logic ext_clk_pin
);
  logic [3:0] cnt_ff;
  logic free_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 4'h0;
      free_ff <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
      if (cnt_ff[1:0] == 2'h3) begin
        free_ff <= ~free_ff;
      end
    end
  end
  // oscillator edge every 2 cycles, detector tick every 4
  assign osc_edge = cnt_ff[0];
  assign pd_tick = cnt_ff[1:0] == 2'h1;
  // pin kept slow, so the pre-divider may be bypassed
  assign ext_clk_pin = loop_sel ? loop_in : free_ff;
endmodule

//--- dv/tb_clock_distribution_divider_control.sv
`timescale 1ns/1ps
module tb_clock_distribution_divider_control;
  import cdd_pkg::*;
  localparam int CAL = 8;
  logic clk, rst, loop_sel, osc_edge, ext_clk_pin, pd_tick;
  logic direct_out, fb_clk, sync_hold, cal_done;
  cdd_bus_s bus;
  logic [7:0] rdata;
  logic [3:0] ch_out;
  logic [3:0] hist;
  logic [4:0] pin_q;
  logic [1:0] zd_div_sel;
  logic [31:0] seed;
  int num_errors, tests_run;
  cdd_top #(.CAL_CYCLES(CAL)) dut (.clk(clk), .rst(rst), .bus(bus),
    .rdata(rdata), .osc_edge(osc_edge), .ext_clk_pin(ext_clk_pin),
    .pd_tick(pd_tick), .ch_out(ch_out), .direct_out(direct_out),
    .fb_clk(fb_clk), .zd_div_sel(zd_div_sel), .sync_hold(sync_hold),
    .cal_done(cal_done));
  cdd_src_model u_src (.clk(clk), .rst(rst), .loop_sel(loop_sel),
    .loop_in(ch_out[zd_div_sel]), .osc_edge(osc_edge), .pd_tick(pd_tick),
    .ext_clk_pin(ext_clk_pin));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    if (num_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask
  task automatic rchk(input string nm, input logic [9:0] a, e, m);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 chk(nm, rdata & m[7:0], e[7:0]);
    @(posedge clk);
  endtask
  task automatic run_len(input int c, input logic lvl, output int n);
    n = 0;
    while (ch_out[c] === lvl && n < 2000) begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  // ticks per half worked out from ratio, duty fix and source rate
  task automatic div(input int c, input logic [3:0] n, m,
    input logic dis, byp, input logic [1:0] src, input int k);
    int hi, lo, x, per, eh, el;
    per = src == 2'b10 ? 2 * k : (src == 2'b00 ? 4 * k : 4);
    wr(10'h1e1, {6'h00, src});
    wr(10'h1e0, 8'(k - 1));
    wr(10'h190 + 10'(3 * c), {m, n});
    wr(10'h191 + 10'(3 * c), {byp, 7'h00});
    wr(10'h192 + 10'(3 * c), {7'h00, dis});
    x = !dis && (m == n || m == n + 1);
    eh = byp ? 1 : (x ? n + m + 2 : 2 * (n + 1));
    el = byp ? 1 : (x ? n + m + 2 : 2 * (m + 1));
    #1 run_len(c, 1'b1, x);
    run_len(c, 1'b0, x);
    run_len(c, 1'b1, x);
    run_len(c, 1'b0, x);
    run_len(c, 1'b1, hi);
    run_len(c, 1'b0, lo);
    chk("ch_hi", hi, eh * per);
    chk("ch_lo", lo, el * per);
    @(posedge clk);
  endtask
  task automatic cal(input logic [1:0] code);
    int n, i;
    wr(10'h018, 8'h00);
    wr(10'h232, 8'h01);
    wr(10'h018, {5'h00, code, 1'b1});
    bus <= '{addr: 10'h232, wdata: 8'h01, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
    #1 chk("hold", sync_hold, 1);
    chk("done_lo", cal_done, 0);
    n = 0;
    i = 0;
    while (sync_hold === 1'b1 && i < 3000) begin
      n += pd_tick;
      if (i == 3) chk("start_lvl", ch_out, 4'b0010);
      @(posedge clk);
      #1 i++;
    end
    chk("ticks", n, CAL * (2 << code));
    chk("done", cal_done, 1);
    @(posedge clk);
    rchk("stat", 10'h01f, 8'h40, 8'h40);
    wr(10'h232, 8'h01);
    #1 chk("no_rerun", sync_hold, 0);
    @(posedge clk);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    bus = '0;
    loop_sel = 1'b0;
    rst = 1'b1;
    seed = 32'h2a91;
    num_errors = 0;
    tests_run = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk("src_rst", 10'h1e1, 8'h02, 8'hff);
    rchk("pre_rst", 10'h1e0, 8'h01, 8'hff);
    rchk("cal_rst", 10'h018, 8'h06, 8'hff);
    rchk("unmapped", 10'h3ff, 8'h00, 8'hff);
    seed = xs(seed);
    wr(10'h01e, seed[7:0]);
    rchk("zd_rw", 10'h01e, seed[7:0] & 8'h1e, 8'h1e);
    wr(10'h194, 8'h20);
    for (int c = 0; c < 4; c++) cal(2'(c));
    div(0, 4'hf, 4'hf, 1'b1, 1'b0, 2'b10, 1);
    div(1, 4'h0, 4'h0, 1'b1, 1'b1, 2'b10, 2);
    div(2, 4'h2, 4'h3, 1'b0, 1'b0, 2'b10, 3);
    div(3, 4'h4, 4'h4, 1'b0, 1'b0, 2'b00, 6);
    div(0, 4'h1, 4'h2, 1'b1, 1'b0, 2'b01, 1);
    repeat (6) begin
      seed = xs(seed);
      div(seed[1:0], seed[5:2], seed[9:6], seed[10], 1'b0, 2'b10,
        1 + seed[13:11] % 6);
    end
    wr(10'h1e1, 8'h03);
    #1 hist = ch_out;
    repeat (100) @(posedge clk);
    #1 chk("no_src", ch_out, hist);
    @(posedge clk);
    wr(10'h1e1, 8'h06);
    #1 hist[0] = direct_out;
    repeat (2) @(posedge clk);
    #1 chk("direct", direct_out, !hist[0]);
    @(posedge clk);
    wr(10'h01e, 8'h02);
    #1 repeat (20) begin
      hist[0] = ch_out[0];
      @(posedge clk);
      #1 chk("fb_int", fb_clk, hist[0]);
    end
    @(posedge clk);
    loop_sel <= 1'b1;
    wr(10'h01e, 8'h16);
    #1 chk("zd_sel", zd_div_sel, 2'h2);
    // pin to feedback is three sync flops, the level flop and fb itself
    pin_q = '0;
    for (int i = 0; i < 40; i++) begin
      pin_q = {pin_q[3:0], ext_clk_pin};
      @(posedge clk);
      #1 if (i > 4) chk("fb_ext", fb_clk, pin_q[4]);
    end
    @(posedge clk);
    // ch3 twins ch0 but for one input cycle of delay: two ticks, 4 clocks
    wr(10'h1e0, 8'h00);
    wr(10'h194, 8'h20);
    for (int c = 0; c < 4; c += 3) begin
      wr(10'h190 + 10'(3 * c), 8'h21);
      wr(10'h191 + 10'(3 * c), 8'(c / 3));
      wr(10'h192 + 10'(3 * c), 8'h01);
    end
    cal(2'h0);
    pin_q = '0;
    for (int i = 0; i < 40; i++) begin
      pin_q = {pin_q[3:0], ch_out[0]};
      @(posedge clk);
      #1 if (i > 3) chk("phase", ch_out[3], pin_q[3]);
    end
    close_out;
  end
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    close_out;
  end
endmodule
